/* File: design/dsml_top.v */
// Two-channel delta-sigma modulator link: bitstream, sync, over-range flag.
// Assumes modulator clock and sync arrive as pins synchronous to sys_clk_in.
`timescale 1ns/10ps
`include "dsml_regs.vh"

// Operation
// - One bit per four modulator clocks
// - Ones density tracks input amplitude
// - Sync rising edge resets conversion sequencer
// - Offset pin adds -60/-35 mV offsets
// - Instability collapses to first order, flag high
// - Fourth order after 32 in-range clocks
// - Sustained over-range makes the flag pulse
// - Sync latched on falling, acts rising
// - Lost clock 40 us powers down
module dsml_top (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire mclk_in,
  input wire sync_in,
  input wire idle_tone_offset_enable_in,
  input wire [35:0] sample_data_in,
  input wire sample_valid_in,
  output wire sample_ready_out,
  output reg [1:0] mod_data_out,
  output reg mod_data_oe_out,
  output reg overrange_flag_out,
  output reg overrange_flag_oe_out
);
  reg mclk_q_r;
  reg sync_lat_r;
  reg sync_pend_r;
  reg [1:0] phase_r;
  reg [`DSML_PD_CNT_W-1:0] idle_cnt_r;
  reg pd_r;
  reg step_d_r;
  reg [35:0] sample_r;
  wire mclk_rise;
  wire mclk_fall;
  wire step;
  wire pop;
  wire fifo_valid;
  wire [35:0] fifo_data;
  wire [1:0] bit_w;
  wire [1:0] first_w;

  // Modulator clock edges
  assign mclk_rise = mclk_in & ~mclk_q_r;
  assign mclk_fall = ~mclk_in & mclk_q_r;
  // One step per divider period, held off at a sync instant
  assign step = mclk_rise & ~sync_pend_r & (phase_r == `DSML_PHASE_LAST);
  // Drain one sample per bit; stalls otherwise so the FIFO fills
  assign pop = step & fifo_valid;

  // Input sample buffer
  dsml_fifo #(
    .WIDTH(36),
    .DEPTH(`DSML_FIFO_DEPTH),
    .AW(`DSML_FIFO_AW)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(sample_data_in),
    .wr_valid_in(sample_valid_in),
    .wr_ready_out(sample_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(step)
  );

  // Clock edge history
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mclk_q_r <= 1'b0;
    end else begin
      mclk_q_r <= mclk_in;
    end
  end

  // Sync caught on falling edge, acts at next rising edge
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_lat_r <= 1'b0;
      sync_pend_r <= 1'b0;
    end else begin
      if (mclk_fall) begin
        sync_lat_r <= sync_in;
        if (sync_in & ~sync_lat_r) begin
          sync_pend_r <= 1'b1;
        end
      end else if (mclk_rise) begin
        sync_pend_r <= 1'b0;
      end
    end
  end

  // Divide-by-four phase, restarted at the sync instant
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= 2'h0;
    end else if (mclk_rise) begin
      if (sync_pend_r) begin
        phase_r <= 2'h0;
      end else begin
        phase_r <= phase_r + 2'h1;
      end
    end
  end

  // Loss-of-clock timer; powered down from reset until clock runs
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_cnt_r <= {`DSML_PD_CNT_W{1'b0}};
      pd_r <= 1'b1;
    end else if (mclk_rise | mclk_fall) begin
      idle_cnt_r <= {`DSML_PD_CNT_W{1'b0}};
      pd_r <= 1'b0;
    end else if (idle_cnt_r == `DSML_PD_CYC - 1) begin
      pd_r <= 1'b1;
    end else begin
      idle_cnt_r <= idle_cnt_r + {{(`DSML_PD_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Current sample, held when the FIFO runs dry
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_r <= 36'h000000000;
    end else if (pop) begin
      sample_r <= fifo_data;
    end
  end

  // Per-channel order control and loop filter
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg order4_r;
      reg [5:0] rec_cnt_r;
      reg [8:0] retry_cnt_r;
      wire signed [17:0] raw_w;
      wire signed [19:0] x_w;
      wire over_w;
      wire in_range_w;
      wire unst_w;

      assign raw_w = sample_r[ch*18 +: 18];
      // Range checks on the raw input
      assign over_w = (raw_w > $signed({1'b0, `DSML_OVR_LIMIT})) |
                      (raw_w < -$signed({1'b0, `DSML_OVR_LIMIT}));
      assign in_range_w = (raw_w <= $signed({1'b0, `DSML_FULL_SCALE})) &
                          (raw_w >= -$signed({1'b0, `DSML_FULL_SCALE}));
      // Internal idle-tone offset when enabled
      assign x_w = {{2{raw_w[17]}}, raw_w} - (idle_tone_offset_enable_in ?
                   ((ch == 0) ? `DSML_OFS_CH1 : `DSML_OFS_CH2) : 20'h00000);
      assign first_w[ch] = ~order4_r;

      dsml_loop u_loop (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .step_in(step),
        .order4_in(order4_r),
        .x_in(x_w),
        .bit_out(bit_w[ch]),
        .unstable_out(unst_w)
      );

      // Collapse on instability, recover after in-range run, retry if stuck
      always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          order4_r <= 1'b1;
          rec_cnt_r <= 6'h00;
          retry_cnt_r <= 9'h000;
        end else if (mclk_rise) begin
          if (order4_r) begin
            rec_cnt_r <= 6'h00;
            retry_cnt_r <= 9'h000;
            if (over_w | unst_w) begin
              order4_r <= 1'b0;
            end
          end else if (in_range_w) begin
            retry_cnt_r <= 9'h000;
            if (rec_cnt_r == `DSML_RECOVER_CYC - 6'h01) begin
              order4_r <= 1'b1;
              rec_cnt_r <= 6'h00;
            end else begin
              rec_cnt_r <= rec_cnt_r + 6'h01;
            end
          end else begin
            rec_cnt_r <= 6'h00;
            if (retry_cnt_r == `DSML_RETRY_CYC - 9'h001) begin
              order4_r <= 1'b1;
              retry_cnt_r <= 9'h000;
            end else begin
              retry_cnt_r <= retry_cnt_r + 9'h001;
            end
          end
        end
      end
    end
  endgenerate

  // Pin registers; outputs float while powered down
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step_d_r <= 1'b0;
      mod_data_out <= 2'h0;
      mod_data_oe_out <= 1'b0;
      overrange_flag_out <= 1'b0;
      overrange_flag_oe_out <= 1'b0;
    end else begin
      step_d_r <= step;
      if (step_d_r) begin
        mod_data_out <= bit_w;
      end
      overrange_flag_out <= |first_w;
      mod_data_oe_out <= ~pd_r;
      overrange_flag_oe_out <= ~pd_r;
    end
  end
endmodule

/* File: design/dsml_regs.vh */
// Constants of the delta-sigma modulator link: timing counts, scaling and limits.
// Assumes a 50 MHz system clock; included by every dsml design file.
`ifndef DSML_REGS_VH
`define DSML_REGS_VH

// System clock rate and loss-of-clock time
`define DSML_SYS_CLK_MHZ 50
`define DSML_PD_TIME_US 40
`define DSML_PD_CYC (`DSML_PD_TIME_US * `DSML_SYS_CLK_MHZ)
`define DSML_PD_CNT_W 12

// Modulator clock divider: one bit per four modulator clocks
`define DSML_MCLK_DIV 4
`define DSML_PHASE_LAST 2'h3

// Input scaling: full scale is 65536 codes of an 18-bit signed sample
`define DSML_SAMPLE_W 18
`define DSML_FULL_SCALE 18'h10000
// Over-range limit 5 percent beyond full scale
`define DSML_OVR_LIMIT 18'h10CCD
// Feedback level giving 86/14 percent ones density at full scale
`define DSML_FEEDBACK 32'h0001638E
// Idle-tone offsets: -60 mV and -35 mV of 2.5 V full scale
`define DSML_OFS_CH1 20'h00625
`define DSML_OFS_CH2 20'h00396
// Fourth-order integrator bound taken as instability
`define DSML_INT_LIMIT 32'h00400000

// Recovery and retry counts in modulator clocks
`define DSML_RECOVER_CYC 6'h20
`define DSML_RETRY_CYC 9'h100

// Sample FIFO geometry
`define DSML_FIFO_DEPTH 16
`define DSML_FIFO_AW 4

`endif

/* File: design/dsml_fifo.v */
// Sample FIFO with valid/ready on both sides and registered write ready.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`include "dsml_regs.vh"

module dsml_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = `DSML_FIFO_DEPTH,
  parameter AW = `DSML_FIFO_AW
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output reg wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in
);
  localparam [AW:0] FULL_CNT = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  reg [AW:0] count_nxt;
  wire do_wr;
  wire do_rd;

  // Transfer handshakes
  assign do_wr = wr_valid_in & wr_ready_out;
  assign do_rd = rd_valid_out & rd_ready_in;
  assign rd_valid_out = (count_r != {(AW+1){1'b0}});
  assign rd_data_out = mem[rd_ptr_r];

  // Occupancy after this cycle
  always @* begin
    count_nxt = count_r;
    if (do_wr & ~do_rd) begin
      count_nxt = count_r + {{AW{1'b0}}, 1'b1};
    end else if (do_rd & ~do_wr) begin
      count_nxt = count_r - {{AW{1'b0}}, 1'b1};
    end
  end

  // Pointers, count and registered ready
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      wr_ready_out <= 1'b0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      count_r <= count_nxt;
      wr_ready_out <= (count_nxt != FULL_CNT);
    end
  end

  // Storage, no reset needed
  always @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= wr_data_in;
    end
  end
endmodule

/* File: design/dsml_loop.v */
// One channel's loop filter: four integrators and a one-bit quantiser.
// Assumes step_in is a one-cycle pulse per output bit from the top.
`timescale 1ns/10ps
`include "dsml_regs.vh"

module dsml_loop (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire step_in,
  input wire order4_in,
  input wire signed [19:0] x_in,
  output reg bit_out,
  output wire unstable_out
);
  reg signed [31:0] i1_r;
  reg signed [31:0] i2_r;
  reg signed [31:0] i3_r;
  reg signed [31:0] i4_r;
  wire signed [31:0] fb_w;
  wire signed [31:0] xe_w;
  wire signed [31:0] sum_w;

  // Feedback follows the last bit
  assign fb_w = bit_out ? `DSML_FEEDBACK : -`DSML_FEEDBACK;
  assign xe_w = {{12{x_in[19]}}, x_in};
  // Feed-forward sum of scaled integrators
  assign sum_w = i1_r + (i2_r >>> 3) + (i3_r >>> 7) + (i4_r >>> 12);
  // Last integrator running away marks instability
  assign unstable_out = order4_in & ((i4_r > $signed(`DSML_INT_LIMIT)) |
                        (i4_r < -$signed(`DSML_INT_LIMIT)));

  // Integrate once per output bit; first order keeps only i1
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      i1_r <= 32'h00000000;
      i2_r <= 32'h00000000;
      i3_r <= 32'h00000000;
      i4_r <= 32'h00000000;
      bit_out <= 1'b0;
    end else if (step_in) begin
      i1_r <= i1_r + xe_w - fb_w;
      if (order4_in) begin
        i2_r <= i2_r + i1_r;
        i3_r <= i3_r + i2_r;
        i4_r <= i4_r + i3_r;
        bit_out <= ~sum_w[31];
      end else begin
        i2_r <= 32'h00000000;
        i3_r <= 32'h00000000;
        i4_r <= 32'h00000000;
        bit_out <= ~i1_r[31];
      end
    end
  end
endmodule

/* File: testbench/dsml_link_monitor.sv */
// Checker on the modulator top ports: bit timing, flag, power-down.
// Assumes mclk_in stays low through reset.
`timescale 1ns/10ps
module dsml_link_monitor (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire mclk_in,
  input wire sync_in,
  input wire sample_ready_out,
  input wire [1:0] mod_data_out,
  input wire mod_data_oe_out,
  input wire overrange_flag_out,
  input wire overrange_flag_oe_out
);
  reg mq_r, sf_r, arm_r;
  reg [1:0] ph_r;
  reg [11:0] idl_r;
  reg [8:0] frc_r;
  wire rise = mclk_in & ~mq_r;
  wire edg = mclk_in ^ mq_r;
  wire stp = rise & ~arm_r & (ph_r == 2'h3);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Shadow divider, sync arming, idle and flag counters
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {mq_r, sf_r, arm_r, ph_r, idl_r, frc_r} <= 26'h0;
    end else begin
      mq_r <= mclk_in;
      if (edg & ~mclk_in) begin
        sf_r <= sync_in;
        if (sync_in & ~sf_r) arm_r <= 1'b1;
      end
      if (rise) begin
        arm_r <= 1'b0;
        ph_r <= arm_r ? 2'h0 : ph_r + 2'h1;
      end
      idl_r <= edg ? 12'h0 : idl_r + {11'h0, ~&idl_r};
      frc_r <= overrange_flag_out ? frc_r + {8'h0, rise & ~&frc_r} : 9'h0;
    end
  end
  sequence s_clk_back;
    !mod_data_oe_out && edg;
  endsequence
  sequence s_flag_up;
    !overrange_flag_out ##1 overrange_flag_out;
  endsequence
  a_bit_step_time: assert property ($changed(mod_data_out) && mod_data_oe_out |-> $past(stp, 2))
    else $error("bit changed off step");
  a_pop_on_step: assert property ($rose(sample_ready_out) && $past(rst_n_in, 2)
    |-> $past(stp, 1) || $past(stp, 2) || $past(stp, 3))
    else $error("pop off step");
  a_flag_rise: assert property (s_flag_up |-> $past(rise, 2))
    else $error("flag rose off mclk rise");
  a_recover_min: assert property ($fell(overrange_flag_out) && mod_data_oe_out
    |-> $past(frc_r) >= 9'd32)
    else $error("early recovery");
  a_pd_early: assert property ($fell(mod_data_oe_out) |-> $past(idl_r) >= 12'd1998)
    else $error("early power-down");
  a_pd_late: assert property (idl_r >= 12'd2003 |-> !mod_data_oe_out)
    else $error("late power-down");
  a_oe_pair: assert property (overrange_flag_oe_out == mod_data_oe_out)
    else $error("enables differ");
  a_wake_up: assert property (s_clk_back |-> ##2 mod_data_oe_out)
    else $error("no wake on clock");
endmodule
bind dsml_top dsml_link_monitor dsml_link_monitor_inst (.sys_clk_in, .rst_n_in, .mclk_in,
  .sync_in, .sample_ready_out, .mod_data_out, .mod_data_oe_out, .overrange_flag_out,
  .overrange_flag_oe_out);

/* File: testbench/dsml_filter_model.sv */
// Filter-side model: makes the modulator clock and sync pulse.
// Assumes run_in gates the clock; clock rests low when stopped.
`timescale 1ns/10ps
module dsml_filter_model #(
  parameter HALF = 4
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire run_in,
  input wire sync_req_in,
  output reg mclk_out,
  output reg sync_out
);
  reg [3:0] cnt_r;
  reg pend_r;
  reg [1:0] hold_r;
  // Clock divider; sync set at an mclk rise, held two periods
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {cnt_r, pend_r, hold_r, mclk_out, sync_out} <= 9'h0;
    end else begin
      if (sync_req_in) pend_r <= 1'b1;
      if (!run_in) begin
        cnt_r <= 4'h0;
        mclk_out <= 1'b0;
      end else if (cnt_r == 4'(HALF - 1)) begin
        cnt_r <= 4'h0;
        mclk_out <= ~mclk_out;
        if (!mclk_out && pend_r) begin
          sync_out <= 1'b1;
          hold_r <= 2'h2;
          pend_r <= 1'b0;
        end else if (!mclk_out && hold_r != 2'h0) begin
          hold_r <= hold_r - 2'h1;
          if (hold_r == 2'h1) sync_out <= 1'b0;
        end
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

/* File: testbench/delta_sigma_modulator_link_tb.sv */
// Bench for the modulator top with the filter model as partner.
// Assumes a 50 MHz clock and mclk of eight system clocks.
`timescale 1ns/10ps
module delta_sigma_modulator_link_tb;
  reg sys_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg run = 1'b0;
  reg sreq = 1'b0;
  reg ofs = 1'b0;
  reg vld = 1'b0;
  reg [35:0] dat = 36'h0;
  wire mclk, sync, rdy, doe, flg, foe;
  wire [1:0] md;
  integer err_total = 0;
  integer checks_done = 0;
  integer o0, o1, s, t0;
  reg stat_err = 1'b0;
  always #10 sys_clk_in = ~sys_clk_in;
  // Filter side: flag logged as status error bit
  always @(posedge sys_clk_in) begin
    if (flg && foe) stat_err <= 1'b1;
  end
  dsml_filter_model #(.HALF(4)) dsml_filter_model_inst (.sys_clk_in, .rst_n_in,
    .run_in(run), .sync_req_in(sreq), .mclk_out(mclk), .sync_out(sync));
  dsml_top dsml_top_inst (.sys_clk_in, .rst_n_in, .mclk_in(mclk), .sync_in(sync),
    .idle_tone_offset_enable_in(ofs), .sample_data_in(dat), .sample_valid_in(vld),
    .sample_ready_out(rdy), .mod_data_out(md), .mod_data_oe_out(doe),
    .overrange_flag_out(flg), .overrange_flag_oe_out(foe));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task tk;
    @(posedge sys_clk_in);
    #1;
  endtask
  // Offer one word, valid held high
  task put(input logic [17:0] a, input logic [17:0] b);
    @(posedge sys_clk_in);
    dat <= {b, a};
    vld <= 1'b1;
  endtask
  // Count ones per channel over n bits, paced by FIFO pops
  task bits(input integer n);
    integer i, w;
    o0 = 0;
    o1 = 0;
    for (i = 0; i < n; i++) begin
      w = 0;
      while (rdy !== 1'b0 && w < 99) begin tk; w++; end
      while (rdy !== 1'b1 && w < 99) begin tk; w++; end
      if (w >= 99) chk(w, 0);
      repeat (4) tk;
      o0 += md[0];
      o1 += md[1];
    end
  endtask
  task wt(input logic lv, input integer lim);
    integer w;
    w = 0;
    while (flg !== lv && w < lim) begin tk; w++; end
    chk(flg, lv);
  endtask
  // Fill FIFO while clock is stopped, then start clock
  task t_fill;
    put(18'h0, 18'h0);
    repeat (20) tk;
    chk(rdy, 0);
    chk(doe, 0);
    chk(md, 0);
    @(posedge sys_clk_in);
    run <= 1'b1;
    repeat (10) tk;
    chk(doe, 1);
  endtask
  // Sync mid-run, then time twenty bits
  task t_rate;
    @(posedge sys_clk_in);
    sreq <= 1'b1;
    @(posedge sys_clk_in);
    sreq <= 1'b0;
    bits(4);
    t0 = $time;
    bits(20);
    chk($time - t0, 12800);
  endtask
  // Ones density at full scale, mid-scale and with idle offset
  task t_dens;
    put(18'h10000, 18'h30000);
    bits(20);
    bits(200);
    chk(o0 >= 160 && o0 <= 184, 1);
    chk(o1 >= 16 && o1 <= 40, 1);
    put(18'h0, 18'h0);
    bits(20);
    bits(600);
    s = o0 + o1;
    chk(o0 >= 285 && o0 <= 315, 1);
    ofs <= 1'b1;
    bits(20);
    bits(600);
    chk(o0 + o1 < s, 1);
    chk(s - o0 - o1 < 40, 1);
    ofs <= 1'b0;
  endtask
  // Over-range: flag rises, pulses, then recovers
  task t_ovr;
    put(18'h12000, 18'h0);
    wt(1, 800);
    wt(0, 2400);
    wt(1, 400);
    put(18'h0, 18'h0);
    wt(0, 2000);
    chk(stat_err, 1);
  endtask
  // Stopped clock powers down, restart wakes
  task t_loss;
    @(posedge sys_clk_in);
    run <= 1'b0;
    repeat (1900) tk;
    chk(doe, 1);
    repeat (150) tk;
    chk({doe, foe}, 0);
    run <= 1'b1;
    repeat (30) tk;
    chk(doe, 1);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_fill;
    t_rate;
    t_dens;
    t_ovr;
    t_loss;
    print_verdict;
  end
  // Watchdog
  initial begin
    #1600000;
    err_total++;
    print_verdict;
  end
endmodule
